// ---- rtl/meter_regs.sv ----
// upper metering register bank with host access port and core-facing values
`timescale 1ns/1ps
`default_nettype none
`include "meter_regs_defs.svh"

module meter_regs
    import meter_regs_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // host access from the serial engine
    input  wire logic        acc_rd,
    input  wire logic        acc_wr,
    input  wire logic [15:0] acc_addr,
    input  wire logic [31:0] acc_wdata,
    input  wire logic        spi_active,
    output var  logic        rd_valid,
    output var  logic        rd_hit,
    output var  xfer_len_t   rd_len,
    output var  logic [31:0] rd_data,
    output var  logic        ss_ctrl_pulse,
    output var  logic [7:0]  ss_ctrl_data,
    // live values from the metering core
    input  wire logic [23:0] react_b,
    input  wire logic [23:0] react_c,
    input  wire logic [23:0] app_a,
    input  wire logic [23:0] app_b,
    input  wire logic [23:0] app_c,
    input  wire logic [15:0] peak_flags,
    input  wire logic [15:0] delay0,
    input  wire logic [15:0] delay1,
    input  wire logic [15:0] delay2,
    input  wire logic [15:0] line_period,
    input  wire logic [15:0] idle_flags,
    input  wire logic [15:0] polarity_flags,
    input  wire logic        checksum_load,
    input  wire logic [31:0] checksum_val,
    // setup values to the metering core
    output var  logic [23:0] nominal_voltage_rms,
    output var  logic [15:0] half_cycle_accum_count,
    output var  logic [15:0] zero_cross_timeout_count,
    output var  logic [15:0] computation_setup,
    output var  logic [15:0] input_amp_gains,
    output var  logic [15:0] pulse_output_setup,
    output var  logic [15:0] pulse1_divider,
    output var  logic [15:0] pulse2_divider,
    output var  logic [15:0] pulse3_divider,
    output var  logic [9:0]  phase_a_delay_trim,
    output var  logic [9:0]  phase_b_delay_trim,
    output var  logic [9:0]  phase_c_delay_trim,
    output var  logic [15:0] device_setup,
    output var  logic [7:0]  measurement_setup,
    output var  logic [7:0]  accumulation_setup,
    output var  logic [7:0]  line_accum_behaviour,
    output var  logic [7:0]  peak_half_cycles,
    output var  logic [7:0]  dip_half_cycles,
    output var  logic [7:0]  pulses_per_latch,
    output var  logic [7:0]  fast_capture_setup,
    output var  logic [7:0]  low_power_overcurrent_level,
    output var  logic [7:0]  low_power_setup,
    output var  logic [31:0] config_checksum
);

    localparam int RW_N = `RW_COUNT;

    localparam logic [15:0] RW_ADDR [RW_N] = '{
        `ADDR_VNOMINAL, `ADDR_HALF_CYC, `ADDR_ZX_TIMEOUT, `ADDR_COMPUTE,
        `ADDR_AMP_GAINS, `ADDR_PULSE_SETUP, `ADDR_PULSE1_DIV, `ADDR_PULSE2_DIV,
        `ADDR_PULSE3_DIV, `ADDR_TRIM_A, `ADDR_TRIM_B, `ADDR_TRIM_C,
        `ADDR_DEV_SETUP, `ADDR_MEAS_SETUP, `ADDR_ACCUM_SETUP, `ADDR_LINE_ACCUM,
        `ADDR_PEAK_CYC, `ADDR_DIP_CYC, `ADDR_PULSES_LAT, `ADDR_FAST_CAP,
        `ADDR_LP_OC_LVL, `ADDR_LP_SETUP};

    localparam int RW_W [RW_N] = '{
        `WIDTH_WIDE, `WIDTH_WORD, `WIDTH_WORD, `WIDTH_WORD,
        `WIDTH_WORD, `WIDTH_WORD, `WIDTH_WORD, `WIDTH_WORD,
        `WIDTH_WORD, `WIDTH_TRIM, `WIDTH_TRIM, `WIDTH_TRIM,
        `WIDTH_WORD, `WIDTH_BYTE, `WIDTH_BYTE, `WIDTH_BYTE,
        `WIDTH_BYTE, `WIDTH_BYTE, `WIDTH_BYTE, `WIDTH_BYTE,
        `WIDTH_BYTE, `WIDTH_BYTE};

    localparam logic [31:0] RW_RST [RW_N] = '{
        `RST_ZERO, `RST_HALF_CYC, `RST_ZX_TIMEOUT, `RST_COMPUTE,
        `RST_ZERO, `RST_PULSE_SETUP, `RST_ZERO, `RST_ZERO,
        `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO,
        `RST_ZERO, `RST_MEAS_SETUP, `RST_ZERO, `RST_LINE_ACCUM,
        `RST_ZERO, `RST_ZERO, `RST_PULSES_LAT, `RST_ZERO,
        `RST_LP_OC_LVL, `RST_ZERO};

    // keep the low w bits; above them zeros or copies of the sign bit
    function automatic word_t fit(input word_t v, input int w, input logic sx);
        word_t r;
        r = '0;
        for (int i = 0; i < 32; i++) begin
            if (i < w) begin
                r[i] = v[i];
            end else begin
                r[i] = sx & v[w - 1];
            end
        end
        return r;
    endfunction

    function automatic xfer_len_t len_of(input int w);
        if (w > `WIDTH_WORD) begin
            return XFER_32;
        end else if (w > `WIDTH_BYTE) begin
            return XFER_16;
        end
        return XFER_8;
    endfunction

    word_t       rw_r [RW_N];
    logic [31:0] checksum_r;
    logic [31:0] rd_data_nxt;
    xfer_len_t   rd_len_nxt;
    logic        rd_hit_nxt;
    logic        rd_valid_r;
    logic        rd_hit_r;
    xfer_len_t   rd_len_r;
    logic [31:0] rd_data_r;
    logic        ss_pulse_r;
    logic [7:0]  ss_data_r;

    // read-only addresses simply have no write path here
    genvar g;
    generate
        for (g = 0; g < RW_N; g++) begin : rw_bank
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    rw_r[g] <= RW_RST[g];
                end else if (acc_wr && acc_addr == RW_ADDR[g]) begin
                    rw_r[g] <= fit(acc_wdata, RW_W[g], 1'b0);
                end
            end
        end
    endgenerate

    // core may refresh the checksum; host writes never reach it
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            checksum_r <= `RST_CHECKSUM;
        end else if (checksum_load) begin
            checksum_r <= checksum_val;
        end
    end

    // slave-select steering only means something on the SPI port
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ss_pulse_r <= 1'b0;
            ss_data_r  <= 8'h00;
        end else begin
            ss_pulse_r <= acc_wr && spi_active && acc_addr == `ADDR_SS_CTRL;
            if (acc_wr && spi_active && acc_addr == `ADDR_SS_CTRL) begin
                ss_data_r <= acc_wdata[7:0];
            end
        end
    end

    always_comb begin
        rd_data_nxt = '0;
        rd_len_nxt  = XFER_NONE;
        rd_hit_nxt  = 1'b0;
        for (int i = 0; i < RW_N; i++) begin
            if (acc_addr == RW_ADDR[i]) begin
                rd_data_nxt = fit(rw_r[i], RW_W[i], 1'b0);
                rd_len_nxt  = len_of(RW_W[i]);
                rd_hit_nxt  = 1'b1;
            end
        end
        unique case (acc_addr)
            `ADDR_REACT_B: rd_data_nxt = fit({8'h00, react_b}, `WIDTH_WIDE, 1'b1);
            `ADDR_REACT_C: rd_data_nxt = fit({8'h00, react_c}, `WIDTH_WIDE, 1'b1);
            `ADDR_APP_A:   rd_data_nxt = fit({8'h00, app_a}, `WIDTH_WIDE, 1'b1);
            `ADDR_APP_B:   rd_data_nxt = fit({8'h00, app_b}, `WIDTH_WIDE, 1'b1);
            `ADDR_APP_C:   rd_data_nxt = fit({8'h00, app_c}, `WIDTH_WIDE, 1'b1);
            `ADDR_CHECKSUM:    rd_data_nxt = checksum_r;
            `ADDR_PEAK_FLAGS:  rd_data_nxt = {16'h0000, peak_flags};
            `ADDR_DELAY0:      rd_data_nxt = {16'h0000, delay0};
            `ADDR_DELAY1:      rd_data_nxt = {16'h0000, delay1};
            `ADDR_DELAY2:      rd_data_nxt = {16'h0000, delay2};
            `ADDR_LINE_PERIOD: rd_data_nxt = {16'h0000, line_period};
            `ADDR_IDLE_FLAGS:  rd_data_nxt = {16'h0000, idle_flags};
            `ADDR_POLARITY:    rd_data_nxt = {16'h0000, polarity_flags};
            default: ;
        endcase
        unique case (acc_addr)
            `ADDR_REACT_B, `ADDR_REACT_C, `ADDR_APP_A, `ADDR_APP_B, `ADDR_APP_C,
            `ADDR_CHECKSUM: begin
                rd_len_nxt = XFER_32;
                rd_hit_nxt = 1'b1;
            end
            `ADDR_PEAK_FLAGS, `ADDR_DELAY0, `ADDR_DELAY1, `ADDR_DELAY2,
            `ADDR_LINE_PERIOD, `ADDR_IDLE_FLAGS, `ADDR_POLARITY: begin
                rd_len_nxt = XFER_16;
                rd_hit_nxt = 1'b1;
            end
            default: ;
        endcase
    end

    // answer one cycle after the request, held until the next one
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rd_valid_r <= 1'b0;
            rd_hit_r   <= 1'b0;
            rd_len_r   <= XFER_NONE;
            rd_data_r  <= '0;
        end else begin
            rd_valid_r <= acc_rd;
            if (acc_rd) begin
                rd_hit_r  <= rd_hit_nxt;
                rd_len_r  <= rd_len_nxt;
                rd_data_r <= rd_data_nxt;
            end
        end
    end

    assign rd_valid      = rd_valid_r;
    assign rd_hit        = rd_hit_r;
    assign rd_len        = rd_len_r;
    assign rd_data       = rd_data_r;
    assign ss_ctrl_pulse = ss_pulse_r;
    assign ss_ctrl_data  = ss_data_r;
    assign config_checksum = checksum_r;

    assign nominal_voltage_rms         = rw_r[0][23:0];
    assign half_cycle_accum_count      = rw_r[1][15:0];
    assign zero_cross_timeout_count    = rw_r[2][15:0];
    assign computation_setup           = rw_r[3][15:0];
    assign input_amp_gains             = rw_r[4][15:0];
    assign pulse_output_setup          = rw_r[5][15:0];
    assign pulse1_divider              = rw_r[6][15:0];
    assign pulse2_divider              = rw_r[7][15:0];
    assign pulse3_divider              = rw_r[8][15:0];
    assign phase_a_delay_trim          = rw_r[9][9:0];
    assign phase_b_delay_trim          = rw_r[10][9:0];
    assign phase_c_delay_trim          = rw_r[11][9:0];
    assign device_setup                = rw_r[12][15:0];
    assign measurement_setup           = rw_r[13][7:0];
    assign accumulation_setup          = rw_r[14][7:0];
    assign line_accum_behaviour        = rw_r[15][7:0];
    assign peak_half_cycles            = rw_r[16][7:0];
    assign dip_half_cycles             = rw_r[17][7:0];
    assign pulses_per_latch            = rw_r[18][7:0];
    assign fast_capture_setup          = rw_r[19][7:0];
    assign low_power_overcurrent_level = rw_r[20][7:0];
    assign low_power_setup             = rw_r[21][7:0];

    // helpers for the checks: nothing written or loaded since reset
    logic wrote_r;
    logic loaded_r;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wrote_r  <= 1'b0;
            loaded_r <= 1'b0;
        end else begin
            wrote_r  <= wrote_r | acc_wr;
            loaded_r <= loaded_r | checksum_load;
        end
    end

    AST_ZP24: assert property (@(posedge clock) disable iff (!reset_n)
        acc_rd && acc_addr == `ADDR_VNOMINAL |=>
        rd_data[31:24] == 8'h00 && rd_len == XFER_32 && rd_hit)
        else $error("24-bit padded read has nonzero top byte");

    AST_ZP20: assert property (@(posedge clock) disable iff (!reset_n)
        fit(acc_wdata, `WIDTH_NARROW, 1'b0) <= 32'h000FFFFF)
        else $error("20-bit padding leaves top twelve bits set");

    AST_SE24: assert property (@(posedge clock) disable iff (!reset_n)
        acc_rd && acc_addr == `ADDR_REACT_B |=>
        rd_data == {{8{$past(react_b[23])}}, $past(react_b)} && rd_len == XFER_32)
        else $error("signed 24-bit read not sign extended");

    AST_ZP10: assert property (@(posedge clock) disable iff (!reset_n)
        acc_rd && acc_addr == `ADDR_TRIM_B |=>
        rd_data[15:10] == 6'h00 && rd_data[9:0] == $past(phase_b_delay_trim)
        && rd_len == XFER_16)
        else $error("phase trim read not zero padded to 16 bits");

    AST_TWOS: assert property (@(posedge clock) disable iff (!reset_n)
        acc_rd && acc_addr == `ADDR_APP_A |=>
        $signed(rd_data) == $signed($past(app_a)))
        else $error("signed read does not keep two's complement value");

    AST_SS_CTRL: assert property (@(posedge clock) disable iff (!reset_n)
        acc_wr && spi_active && acc_addr == `ADDR_SS_CTRL |=>
        ss_ctrl_pulse && ss_ctrl_data == $past(acc_wdata[7:0]))
        else $error("slave-select write not passed on");

    AST_SS_IDLE: assert property (@(posedge clock) disable iff (!reset_n)
        ss_ctrl_pulse |-> $past(acc_wr) && $past(spi_active) && $past(acc_addr) == `ADDR_SS_CTRL)
        else $error("slave-select pulse without its write");

    AST_CHECKSUM_RST: assert property (@(posedge clock) disable iff (!reset_n)
        !loaded_r |-> config_checksum == `RST_CHECKSUM)
        else $error("checksum reset value wrong");

    AST_RO_WRITE: assert property (@(posedge clock) disable iff (!reset_n)
        acc_wr && acc_addr == `ADDR_CHECKSUM && !checksum_load |=> $stable(config_checksum))
        else $error("host write changed read-only checksum");

    AST_HALF_CYC: assert property (@(posedge clock) disable iff (!reset_n)
        acc_wr && acc_addr == `ADDR_HALF_CYC |=>
        half_cycle_accum_count == $past(acc_wdata[15:0]) [*1] ##0 rw_r[1][31:16] == 16'h0000)
        else $error("half-cycle count write not taken");

    AST_BYTE_CNT: assert property (@(posedge clock) disable iff (!reset_n)
        acc_wr && acc_addr == `ADDR_PULSES_LAT ##1 acc_rd && acc_addr == `ADDR_PULSES_LAT
        |=> rd_data == {24'h000000, $past(acc_wdata[7:0], 2)} && rd_len == XFER_8)
        else $error("pulses-per-latch readback wrong");

    AST_COUNT_RST: assert property (@(posedge clock) disable iff (!reset_n)
        !wrote_r |-> half_cycle_accum_count == 16'hFFFF && pulses_per_latch == 8'h01
        && peak_half_cycles == 8'h00 && dip_half_cycles == 8'h00)
        else $error("count register reset value wrong");

    AST_LEVEL_RST: assert property (@(posedge clock) disable iff (!reset_n)
        !wrote_r |-> low_power_overcurrent_level == 8'h07 && nominal_voltage_rms == 24'h000000)
        else $error("level reset value wrong");

    AST_NOMINAL_VOLTAGE_RMS_WR: assert property (@(posedge clock) disable iff (!reset_n)
        acc_wr && acc_addr == `ADDR_VNOMINAL |=>
        nominal_voltage_rms == $past(acc_wdata[23:0]))
        else $error("nominal voltage write not taken");

    AST_SETUP_RST: assert property (@(posedge clock) disable iff (!reset_n)
        !wrote_r |-> measurement_setup == 8'h16 && line_accum_behaviour == 8'h78
        && computation_setup == 16'h01FF && pulse_output_setup == 16'h0E88)
        else $error("setup register reset value wrong");

endmodule
`default_nettype wire

// ---- rtl/meter_regs_defs.svh ----
// offsets, reset values and widths of the upper metering register bank
// Notes on behaviour
// - A 24-bit register sent zero padded goes out as 32 bits with the top eight bits zero.
// - A 20-bit register sent zero padded goes out as 32 bits with the top twelve bits zero.
// - A 24-bit signed waveform or power value goes out as 32 bits, its sign copied upward.
// - A 10-bit phase trim goes out as 16 bits with the top six bits zero.
// - Signed registers hold two's complement values, unsigned ones plain binary.
// - A host write to the slave-select address steers slave-select while SPI is in use.
// - The 32-bit configuration checksum is read only and resets to 9AE5E8B1.
// - The 16-bit half-cycle accumulation count is writable and resets to FFFF.
// - The 8-bit pulses-per-latch count is writable and resets to 01.
// - The 8-bit peak detection half-cycle count is writable and resets to 00.
// - The 8-bit dip detection half-cycle count is writable and resets to 00.
// - The 8-bit second low power mode overcurrent level is writable and resets to 07.
// - The signed 24-bit nominal voltage rms is writable and resets to zero.
// - Measurement, line accumulation, computation and pulse setups reset to 16, 78, 01FF, 0E88.
`ifndef METER_REGS_DEFS_SVH
`define METER_REGS_DEFS_SVH

`define WIDTH_WIDE       24
`define WIDTH_NARROW     20
`define WIDTH_WORD       16
`define WIDTH_TRIM       10
`define WIDTH_BYTE       8
`define RW_COUNT         22

`define ADDR_REACT_B     16'hE517
`define ADDR_REACT_C     16'hE518
`define ADDR_APP_A       16'hE519
`define ADDR_APP_B       16'hE51A
`define ADDR_APP_C       16'hE51B
`define ADDR_CHECKSUM    16'hE51F
`define ADDR_VNOMINAL    16'hE520
`define ADDR_PEAK_FLAGS  16'hE600
`define ADDR_DELAY0      16'hE601
`define ADDR_DELAY1      16'hE602
`define ADDR_DELAY2      16'hE603
`define ADDR_LINE_PERIOD 16'hE607
`define ADDR_IDLE_FLAGS  16'hE608
`define ADDR_HALF_CYC    16'hE60C
`define ADDR_ZX_TIMEOUT  16'hE60D
`define ADDR_COMPUTE     16'hE60E
`define ADDR_AMP_GAINS   16'hE60F
`define ADDR_PULSE_SETUP 16'hE610
`define ADDR_PULSE1_DIV  16'hE611
`define ADDR_PULSE2_DIV  16'hE612
`define ADDR_PULSE3_DIV  16'hE613
`define ADDR_TRIM_A      16'hE614
`define ADDR_TRIM_B      16'hE615
`define ADDR_TRIM_C      16'hE616
`define ADDR_POLARITY    16'hE617
`define ADDR_DEV_SETUP   16'hE618
`define ADDR_MEAS_SETUP  16'hE700
`define ADDR_ACCUM_SETUP 16'hE701
`define ADDR_LINE_ACCUM  16'hE702
`define ADDR_PEAK_CYC    16'hE703
`define ADDR_DIP_CYC     16'hE704
`define ADDR_PULSES_LAT  16'hE705
`define ADDR_FAST_CAP    16'hE706
`define ADDR_SS_CTRL     16'hEBFF
`define ADDR_LP_OC_LVL   16'hEC00
`define ADDR_LP_SETUP    16'hEC01

`define RST_CHECKSUM     32'h9AE5E8B1
`define RST_HALF_CYC     32'h0000FFFF
`define RST_ZX_TIMEOUT   32'h0000FFFF
`define RST_COMPUTE      32'h000001FF
`define RST_PULSE_SETUP  32'h00000E88
`define RST_MEAS_SETUP   32'h00000016
`define RST_LINE_ACCUM   32'h00000078
`define RST_PULSES_LAT   32'h00000001
`define RST_LP_OC_LVL    32'h00000007
`define RST_ZERO         32'h00000000

`endif

// ---- rtl/meter_regs_pkg.sv ----
// types shared by the metering register bank
package meter_regs_pkg;
    typedef enum logic [1:0] {XFER_NONE, XFER_8, XFER_16, XFER_32} xfer_len_t;
    typedef logic [31:0] word_t;
endpackage

// ---- tb/host_model.sv ----
// host-side model that reaches the register bank through its access port
`timescale 1ns/1ps
`default_nettype none
module host_model
    import meter_regs_pkg::*;
(
    // clock
    input  wire logic        clock,
    // access requests
    output var  logic        acc_rd,
    output var  logic        acc_wr,
    output var  logic [15:0] acc_addr,
    output var  logic [31:0] acc_wdata,
    // read answer
    input  wire logic        rd_valid,
    input  wire logic        rd_hit,
    input  wire xfer_len_t   rd_len,
    input  wire word_t       rd_data
);
    initial begin
        acc_rd = 1'b0;
        acc_wr = 1'b0;
        acc_addr = 16'h0000;
        acc_wdata = 32'h00000000;
    end

    function automatic logic reserved(input logic [15:0] a);
        return (a >= 16'hE521 && a <= 16'hE52E) || (a >= 16'hE604 && a <= 16'hE606)
            || (a >= 16'hE609 && a <= 16'hE60B);
    endfunction

    // EBFF is written like any register; that is how slave-select is steered
    task automatic wr(input logic [15:0] a, input word_t d);
        if (reserved(a)) begin
            return;
        end
        @(posedge clock);
        #1;
        acc_wr = 1'b1;
        acc_addr = a;
        acc_wdata = d;
        @(posedge clock);
        #1;
        acc_wr = 1'b0;
        // released lines show garbage so a stale value cannot pass
        acc_addr = ~a;
        acc_wdata = ~d;
    endtask

    // write, then read the same address in the very next cycle
    task automatic wr_rd(input logic [15:0] a, input word_t d, output logic v,
                         output logic h, output xfer_len_t l, output word_t q);
        @(posedge clock);
        #1;
        acc_wr = 1'b1;
        acc_addr = a;
        acc_wdata = d;
        @(posedge clock);
        #1;
        acc_wr = 1'b0;
        acc_rd = 1'b1;
        acc_wdata = ~d;
        @(posedge clock);
        #1;
        acc_rd = 1'b0;
        acc_addr = ~a;
        v = rd_valid;
        h = rd_hit;
        l = rd_len;
        q = rd_data;
    endtask

    task automatic rd(input logic [15:0] a, output logic v, output logic h,
                      output xfer_len_t l, output word_t d);
        @(posedge clock);
        #1;
        acc_rd = 1'b1;
        acc_addr = a;
        @(posedge clock);
        #1;
        acc_rd = 1'b0;
        acc_addr = ~a;
        v = rd_valid;
        h = rd_hit;
        l = rd_len;
        d = rd_data;
    endtask
endmodule
`default_nettype wire

// ---- tb/metering_register_map_upper_tb.sv ----
// self-checking bench for the upper metering register bank
`timescale 1ns/1ps
`default_nettype none
module metering_register_map_upper_tb
    import meter_regs_pkg::*;
;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic        spi_active = 1'b0;
    logic        checksum_load = 1'b0;
    word_t       checksum_val = 32'h00000000;
    logic [23:0] live24 [5] = '{24'h800001, 24'h7FFFFF, 24'hFFFFFF, 24'h000000, 24'hC00000};
    logic [15:0] live16 [7] = '{16'h8001, 16'h1234, 16'hFFFF, 16'h0001, 16'h4E20, 16'h0007, 16'hA5A5};
    logic        acc_rd, acc_wr, rd_valid, rd_hit, ss_ctrl_pulse;
    logic [15:0] acc_addr, half_cycle_accum_count;
    logic [31:0] acc_wdata;
    xfer_len_t   rd_len;
    word_t       rd_data, config_checksum;
    logic [7:0]  ss_ctrl_data, pulses_per_latch;
    logic [9:0]  phase_a_delay_trim;
    logic [23:0] nominal_voltage_rms;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          cyc = 0;

    always #2.5 clock = ~clock;

    host_model hm (.clock(clock), .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata), .rd_valid(rd_valid), .rd_hit(rd_hit), .rd_len(rd_len),
        .rd_data(rd_data));

    meter_regs dut (.clock(clock), .reset_n(reset_n), .acc_rd(acc_rd), .acc_wr(acc_wr),
        .acc_addr(acc_addr), .acc_wdata(acc_wdata), .spi_active(spi_active),
        .rd_valid(rd_valid), .rd_hit(rd_hit), .rd_len(rd_len), .rd_data(rd_data),
        .ss_ctrl_pulse(ss_ctrl_pulse), .ss_ctrl_data(ss_ctrl_data),
        .react_b(live24[0]), .react_c(live24[1]), .app_a(live24[2]), .app_b(live24[3]),
        .app_c(live24[4]), .peak_flags(live16[0]), .delay0(live16[1]), .delay1(live16[2]),
        .delay2(live16[3]), .line_period(live16[4]), .idle_flags(live16[5]),
        .polarity_flags(live16[6]), .checksum_load(checksum_load),
        .checksum_val(checksum_val), .nominal_voltage_rms(nominal_voltage_rms),
        .half_cycle_accum_count(half_cycle_accum_count), .zero_cross_timeout_count(),
        .computation_setup(), .input_amp_gains(), .pulse_output_setup(), .pulse1_divider(),
        .pulse2_divider(), .pulse3_divider(), .phase_a_delay_trim(phase_a_delay_trim),
        .phase_b_delay_trim(), .phase_c_delay_trim(), .device_setup(),
        .measurement_setup(), .accumulation_setup(), .line_accum_behaviour(),
        .peak_half_cycles(), .dip_half_cycles(), .pulses_per_latch(pulses_per_latch),
        .fast_capture_setup(), .low_power_overcurrent_level(), .low_power_setup(),
        .config_checksum(config_checksum));

    task automatic chk(input string n, input word_t s, input word_t e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    // hit is implied by a non-empty transfer length
    task automatic rdchk(input logic [15:0] a, input word_t e, input xfer_len_t l);
        logic      v;
        logic      h;
        xfer_len_t gl;
        word_t     d;
        hm.rd(a, v, h, gl, d);
        chk($sformatf("rd_valid %h", a), {31'h0, v}, 32'h1);
        chk($sformatf("rd_hit %h", a), {31'h0, h}, {31'h0, l != XFER_NONE});
        chk($sformatf("rd_len %h", a), {30'h0, gl}, {30'h0, l});
        chk($sformatf("rd_data %h", a), d, e);
    endtask

    task automatic t_reset_values();
        logic [15:0] ra [15] = '{16'hE51F, 16'hE520, 16'hE60C, 16'hE60D, 16'hE60E, 16'hE610,
            16'hE614, 16'hE700, 16'hE701, 16'hE702, 16'hE703, 16'hE704, 16'hE705, 16'hEC00,
            16'hEC01};
        word_t re [15] = '{32'h9AE5E8B1, 32'h0, 32'hFFFF, 32'hFFFF, 32'h01FF, 32'h0E88, 32'h0,
            32'h16, 32'h0, 32'h78, 32'h0, 32'h0, 32'h01, 32'h07, 32'h0};
        xfer_len_t rl [15] = '{XFER_32, XFER_32, XFER_16, XFER_16, XFER_16, XFER_16, XFER_16,
            XFER_8, XFER_8, XFER_8, XFER_8, XFER_8, XFER_8, XFER_8, XFER_8};
        chk("half_cycle_accum_count", {16'h0, half_cycle_accum_count}, 32'hFFFF);
        chk("config_checksum", config_checksum, 32'h9AE5E8B1);
        for (int i = 0; i < 15; i++) begin
            rdchk(ra[i], re[i], rl[i]);
        end
    endtask

    task automatic t_live_values();
        logic [15:0] la [7] = '{16'hE600, 16'hE601, 16'hE602, 16'hE603, 16'hE607, 16'hE608,
            16'hE617};
        for (int i = 0; i < 5; i++) begin
            rdchk(16'hE517 + 16'(i), {{8{live24[i][23]}}, live24[i]}, XFER_32);
        end
        for (int i = 0; i < 7; i++) begin
            rdchk(la[i], {16'h0, live16[i]}, XFER_16);
        end
    endtask

    // all-ones writes show that only the register width is kept
    task automatic t_write_widths();
        logic [15:0] wa [9] = '{16'hE520, 16'hE614, 16'hE60C, 16'hE705, 16'hEC00, 16'hE702,
            16'hE615, 16'hE703, 16'hE704};
        word_t wd [9] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h12345678, 32'hFFFFFFFF, 32'hA5,
            32'h3C, 32'hFFFFFFFF, 32'h5A, 32'hC3};
        word_t we [9] = '{32'h00FFFFFF, 32'h03FF, 32'h5678, 32'hFF, 32'hA5, 32'h3C, 32'h03FF,
            32'h5A, 32'hC3};
        xfer_len_t wl [9] = '{XFER_32, XFER_16, XFER_16, XFER_8, XFER_8, XFER_8, XFER_16,
            XFER_8, XFER_8};
        logic      v;
        logic      h;
        xfer_len_t gl;
        word_t     d;
        for (int i = 0; i < 9; i++) begin
            hm.wr(wa[i], wd[i]);
            rdchk(wa[i], we[i], wl[i]);
        end
        chk("nominal_voltage_rms", {8'h0, nominal_voltage_rms}, 32'h00FFFFFF);
        chk("phase_a_delay_trim", {22'h0, phase_a_delay_trim}, 32'h03FF);
        chk("pulses_per_latch", {24'h0, pulses_per_latch}, 32'hFF);
        hm.wr_rd(16'hE705, 32'h0000005A, v, h, gl, d);
        chk("pulses_per_latch back to back", d, 32'h5A);
        chk("rd_len back to back", {30'h0, gl}, {30'h0, XFER_8});
    endtask

    task automatic t_read_only();
        hm.wr(16'hE517, 32'h00000000);
        rdchk(16'hE517, 32'hFF800001, XFER_32);
        hm.wr(16'hE51F, 32'h00000000);
        rdchk(16'hE51F, 32'h9AE5E8B1, XFER_32);
        @(posedge clock);
        #1;
        checksum_load = 1'b1;
        checksum_val = 32'h13572468;
        @(posedge clock);
        #1;
        checksum_load = 1'b0;
        checksum_val = 32'hECA8DB97;
        chk("config_checksum", config_checksum, 32'h13572468);
    endtask

    task automatic t_slave_select();
        spi_active = 1'b1;
        hm.wr(16'hEBFF, 32'h3C);
        chk("ss_ctrl_pulse", {31'h0, ss_ctrl_pulse}, 32'h1);
        chk("ss_ctrl_data", {24'h0, ss_ctrl_data}, 32'h3C);
        @(posedge clock);
        #1;
        chk("ss_ctrl_pulse", {31'h0, ss_ctrl_pulse}, 32'h0);
        spi_active = 1'b0;
        hm.wr(16'hEBFF, 32'h55);
        chk("ss_ctrl_pulse", {31'h0, ss_ctrl_pulse}, 32'h0);
        chk("ss_ctrl_data", {24'h0, ss_ctrl_data}, 32'h3C);
    endtask

    task automatic t_unmapped();
        logic [15:0] ua [5] = '{16'hE521, 16'hE52E, 16'hE604, 16'hEBFF, 16'hE800};
        for (int i = 0; i < 5; i++) begin
            rdchk(ua[i], 32'h0, XFER_NONE);
        end
    endtask

    task automatic complete_run();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ceiling well above the roughly 120 cycles the sequence needs
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            complete_run();
        end
    end

    initial begin
        repeat (2) @(posedge clock);
        #1;
        reset_n = 1'b1;
        t_reset_values();
        t_live_values();
        t_write_widths();
        t_read_only();
        t_slave_select();
        t_unmapped();
        complete_run();
    end
endmodule
`default_nettype wire
